// file: logic/twes_regs.svh
`ifndef TWES_REGS_SVH
`define TWES_REGS_SVH

// Register byte offsets
`define TWES_CTRL_OFS 4'h0
`define TWES_STATUS_OFS 4'h4
`define TWES_RADDR_OFS 4'h8

// Field positions
`define TWES_CTRL_EN_BIT 0
`define TWES_STAT_BUSY_BIT 0
`define TWES_STAT_ACTIVE_BIT 1
`define TWES_STAT_WPEND_BIT 2

// Reset values
`define TWES_CTRL_RST 1'h1

// Word format
`define TWES_WORD_BITS 4'h8
`define TWES_PROT_QUARTER 2'h3

// Timing
`define TWES_MCLK_MHZ 250
`define TWES_SCL_MAX_KHZ 400
`define TWES_INTERNAL_WRITE_CYCLE_TIME_MS 5
`define TWES_WC_CYCLES (`TWES_INTERNAL_WRITE_CYCLE_TIME_MS * 1000 * `TWES_MCLK_MHZ)

`endif

// file: logic/twes_pkg.sv
package twes_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_ADDRH,
        ST_ADDRL,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK,
        ST_IGNORE
    } twes_state_e;

endpackage

// file: logic/twes_eeprom_slave.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "twes_regs.svh"

// What this block does
// - Sample serial data on clock rise, change driven data after clock fall.
// - Data line is open drain: pull low or release, never drive high.
// - Data line changes only while clock is low, except start and stop.
// - Data falling while clock high is a start; it opens a transaction.
// - Data rising while clock high is a stop; after a read, go idle.
// - Stop in a write launches the timed write cycle, then idle.
// - Words are eight bits; receiver pulls low on ninth clock.
// - In a write, acknowledge the address word, both address bytes and the one data byte with a zero.
// - In a read, acknowledge a matching read-direction address word.
// - After a read byte release the line; on master zero send next byte.
// - Master no-acknowledge followed by stop ends the read, back to idle.
// - No zero acknowledge and no stop: stay released, send nothing more.
// - Address word is type code, select bits 2,1,0, then direction.
// - Respond only when select bits equal the strapped select pins.
// - Direction bit zero starts a write, one starts a read.
// - Full match acknowledges when enabled and not busy; any mismatch is ignored without acknowledge until the next start or stop.
// - Byte write is two memory address bytes then one data byte, all acknowledged.
// - During the timed write cycle the bus has no effect on the array.
// - Protect pin high refuses writes to the upper quarter of the array.
// - Protect pin low allows all writes; reads are served at either protect pin level.
// - Withhold address acknowledge while busy writing, so the master can poll.
module twes_eeprom_slave
    import twes_pkg::*;
#(
    parameter int MEM_AW = 13,
    parameter int WC_CYCLES = `TWES_WC_CYCLES,
    // Device type code value is arbitrary
    parameter logic [3:0] DEV_TYPE = 4'h6
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps
    input wire logic select_pin_bit0,
    input wire logic select_pin_bit1,
    input wire logic select_pin_bit2,
    input wire logic write_protect,
    // Status
    output logic write_busy,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    localparam int WCW = $clog2(WC_CYCLES + 1);

    // Array is not reset; contents unknown until written
    logic [7:0] mem [0:(1 << MEM_AW) - 1];

    // Pin order: scl, sda, select bits 0 to 2, write protect
    localparam int NPIN = 6;
    // Bus lines idle high so no false edge follows reset
    localparam logic [NPIN-1:0] PIN_IDLE = 6'h03;
    logic [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_sync;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic scl_now;
    logic sda_now;
    logic [2:0] sel_now;
    logic wp_now;

    // Protocol state
    twes_state_e state_reg;
    twes_state_e after_ack_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] addr_hi_reg;
    logic [MEM_AW-1:0] addr_reg;
    logic [7:0] wdata_reg;
    logic wpend_reg;
    logic ack_ok_reg;
    logic commit_reg;
    logic sda_oe_reg;
    logic sda_out_reg;

    // Timed write cycle
    logic busy_reg;
    logic [WCW-1:0] wc_cnt_reg;

    // Register side
    logic ctrl_en_reg;
    logic waitreq_reg;
    logic [31:0] rdata_reg;

    // Decoded bus events
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_bit;
    logic [MEM_AW-1:0] addr_next;
    logic [15:0] addr_full;
    logic protected_hit;

    // Bit counter holds a whole word; shared by receive and send
    function automatic logic word_full(input logic [3:0] cnt);
        word_full = (cnt == `TWES_WORD_BITS);
    endfunction

    // Address word check against type code and straps
    function automatic logic addr_match(input logic [7:0] word, input logic [2:0] sel);
        addr_match = (word[7:4] == DEV_TYPE) && (word[3:1] == sel);
    endfunction

    // Register read mux
    function automatic logic [31:0] reg_read(input logic [3:0] ofs);
        reg_read = 32'h0000_0000;
        if (ofs == `TWES_CTRL_OFS) begin
            reg_read[`TWES_CTRL_EN_BIT] = ctrl_en_reg;
        end else if (ofs == `TWES_STATUS_OFS) begin
            reg_read[`TWES_STAT_BUSY_BIT] = busy_reg;
            reg_read[`TWES_STAT_ACTIVE_BIT] = (state_reg != ST_IDLE);
            reg_read[`TWES_STAT_WPEND_BIT] = wpend_reg;
        end else if (ofs == `TWES_RADDR_OFS) begin
            reg_read[MEM_AW-1:0] = addr_reg;
        end
    endfunction

    assign pin_raw = {write_protect, select_pin_bit2, select_pin_bit1, select_pin_bit0, sda_in, scl_in};
    // Every pin passes two flops before any logic reads it
    // Sampling at 250 MHz leaves hundreds of samples per bit at 400 kHz
    for (genvar gi = 0; gi < NPIN; gi++) begin : g_sync
        logic meta_reg;
        logic sync_reg;
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                meta_reg <= PIN_IDLE[gi];
                sync_reg <= PIN_IDLE[gi];
            end else begin
                meta_reg <= pin_raw[gi];
                sync_reg <= meta_reg;
            end
        end
        assign pin_sync[gi] = sync_reg;
    end

    assign scl_now = pin_sync[0];
    assign sda_now = pin_sync[1];
    assign sel_now = pin_sync[4:2];
    assign wp_now = pin_sync[5];

    // Previous synchronised level, for edges and conditions
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_now;
            sda_prev_reg <= sda_now;
        end
    end

    assign scl_rise = scl_now & ~scl_prev_reg;
    assign scl_fall = ~scl_now & scl_prev_reg;
    assign start_det = scl_now & scl_prev_reg & sda_prev_reg & ~sda_now;
    assign stop_det = scl_now & scl_prev_reg & ~sda_prev_reg & sda_now;
    assign sda_bit = sda_now;
    assign addr_next = addr_reg + 1'b1;
    assign addr_full = {addr_hi_reg, shift_reg};
    assign protected_hit = wp_now && (addr_reg[MEM_AW-1:MEM_AW-2] == `TWES_PROT_QUARTER);

    // Bus protocol engine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            after_ack_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            addr_hi_reg <= 8'h00;
            addr_reg <= '0;
            wdata_reg <= 8'h00;
            wpend_reg <= 1'b0;
            ack_ok_reg <= 1'b0;
            commit_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            commit_reg <= 1'b0;
            if (stop_det) begin
                sda_oe_reg <= 1'b0;
                state_reg <= ST_IDLE;
                if (wpend_reg && !busy_reg) begin
                    commit_reg <= 1'b1;
                end
                wpend_reg <= 1'b0;
            end else if (start_det) begin
                // Restart without stop drops a pending byte write
                sda_oe_reg <= 1'b0;
                state_reg <= ST_DEVADDR;
                bit_cnt_reg <= 4'h0;
                wpend_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_DEVADDR, ST_ADDRH, ST_ADDRL, ST_WDATA: begin
                        if (scl_rise && !word_full(bit_cnt_reg)) begin
                            shift_reg <= {shift_reg[6:0], sda_bit};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && word_full(bit_cnt_reg)) begin
                            if (state_reg == ST_DEVADDR) begin
                                if (addr_match(shift_reg, sel_now) && ctrl_en_reg && !busy_reg) begin
                                    sda_oe_reg <= 1'b1;
                                    state_reg <= ST_ACK;
                                    tx_reg <= mem[addr_reg];
                                    after_ack_reg <= shift_reg[0] ? ST_RDATA : ST_ADDRH;
                                end else begin
                                    state_reg <= ST_IGNORE;
                                end
                            end else if (state_reg == ST_ADDRH) begin
                                addr_hi_reg <= shift_reg;
                                sda_oe_reg <= 1'b1;
                                state_reg <= ST_ACK;
                                after_ack_reg <= ST_ADDRL;
                            end else if (state_reg == ST_ADDRL) begin
                                addr_reg <= addr_full[MEM_AW-1:0];
                                sda_oe_reg <= 1'b1;
                                state_reg <= ST_ACK;
                                after_ack_reg <= ST_WDATA;
                            end else begin
                                wdata_reg <= shift_reg;
                                wpend_reg <= 1'b1;
                                sda_oe_reg <= 1'b1;
                                state_reg <= ST_ACK;
                                // Single byte only: further bytes go unanswered
                                after_ack_reg <= ST_IGNORE;
                            end
                        end
                    end
                    // Hand-off on the ninth falling edge
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg <= after_ack_reg;
                            if (after_ack_reg == ST_RDATA) begin
                                sda_oe_reg <= ~tx_reg[7];
                            end else begin
                                sda_oe_reg <= 1'b0;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (word_full(bit_cnt_reg)) begin
                                sda_oe_reg <= 1'b0;
                                state_reg <= ST_RACK;
                            end else begin
                                sda_oe_reg <= ~tx_reg[6];
                                tx_reg <= {tx_reg[6:0], 1'b0};
                            end
                        end
                    end
                    // Master acknowledge decides whether another byte follows
                    ST_RACK: begin
                        if (scl_rise) begin
                            ack_ok_reg <= ~sda_bit;
                            if (!sda_bit) begin
                                addr_reg <= addr_next;
                                tx_reg <= mem[addr_next];
                            end
                        end else if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            if (ack_ok_reg) begin
                                state_reg <= ST_RDATA;
                                sda_oe_reg <= ~tx_reg[7];
                            end else begin
                                state_reg <= ST_IGNORE;
                                sda_oe_reg <= 1'b0;
                            end
                        end
                    end
                    ST_IGNORE: begin
                        sda_oe_reg <= 1'b0;
                    end
                    default: begin
                        sda_oe_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Array write at the start of the timed cycle; protected writes are dropped
    always_ff @(posedge mclk) begin
        if (commit_reg && !protected_hit) begin
            mem[addr_reg] <= wdata_reg;
        end
    end

    // Timed write cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            wc_cnt_reg <= '0;
        end else if (commit_reg) begin
            busy_reg <= 1'b1;
            wc_cnt_reg <= WCW'(WC_CYCLES - 1);
        end else if (busy_reg) begin
            if (wc_cnt_reg == '0) begin
                busy_reg <= 1'b0;
            end else begin
                wc_cnt_reg <= wc_cnt_reg - 1'b1;
            end
        end
    end

    // Open-drain data: the output level is always low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sda_out_reg <= 1'b0;
        end else begin
            sda_out_reg <= 1'b0;
        end
    end

    // Avalon slave: fixed one wait state, answer at the second edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            waitreq_reg <= 1'b1;
        end else if ((avs_read || avs_write) && waitreq_reg) begin
            waitreq_reg <= 1'b0;
        end else begin
            waitreq_reg <= 1'b1;
        end
    end

    // Read data latched with the answer, held until the next read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read && waitreq_reg) begin
            rdata_reg <= reg_read(avs_address);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_en_reg <= `TWES_CTRL_RST;
        end else if (avs_write && !waitreq_reg && avs_byteenable[0]) begin
            if (avs_address == `TWES_CTRL_OFS) begin
                ctrl_en_reg <= avs_writedata[`TWES_CTRL_EN_BIT];
            end
        end
    end

    // Outputs come straight from flops
    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign write_busy = busy_reg;
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = waitreq_reg;

endmodule

// file: tb/twes_eeprom_slave_monitor.sv
`timescale 1ns/1ps
module twes_eeprom_slave_monitor #(
    parameter int WC_CYCLES = 1250000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Status and handshake
    input wire logic write_busy,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    logic [31:0] busy_cnt_reg;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Counts the cycle length; a repetition would be far too long
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= write_busy ? busy_cnt_reg + 32'h1 : 32'h0;
        end
    end
    od_low_a: assert property (!sda_out) else $error("data line driven high");
    oe_clk_low_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved in clock high");
    oe_after_fall_a: assert property ($rose(sda_oe) |-> !$past(scl_in, 2)) else $error("pull not after fall");
    ack_hold_a: assert property ($rose(scl_in) && sda_oe |-> sda_oe [*4]) else $error("pull dropped early");
    busy_at_stop_a: assert property ($rose(write_busy) |-> scl_in && sda_in) else $error("cycle without stop");
    busy_len_a: assert property ($fell(write_busy) |-> busy_cnt_reg == 32'(WC_CYCLES))
        else $error("write cycle length off");
    busy_quiet_a: assert property (write_busy |-> !$rose(sda_oe)) else $error("answered while busy");
    wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("wait low too long");
endmodule

bind twes_eeprom_slave twes_eeprom_slave_monitor #(.WC_CYCLES(WC_CYCLES)) mon (.mclk(mclk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// file: tb/twes_i2c_master.sv
`timescale 1ns/1ps
module twes_i2c_master (
    // Clock
    input wire logic mclk,
    // Bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Quarter of the 80 ns serial clock
    task automatic q();
        repeat (5) @(posedge mclk);
    endtask
    // Works from idle and as a restart after a byte
    task automatic start_c();
        sda_pull <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic stop_c();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b0;
        q();
    endtask
    task automatic put_bit(input logic b, output logic r);
        sda_pull <= ~b;
        q();
        scl <= 1'b1;
        q();
        r = sda;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
        end
        put_bit(~mack, r);
    endtask
endmodule

// file: tb/two_wire_eeprom_slave_byte_write_tb.sv
`timescale 1ns/1ps
module two_wire_eeprom_slave_byte_write_tb;
    localparam int WC = 400;
    // Type code value is arbitrary
    localparam logic [3:0] TYPE_CODE = 4'h6;
    logic mclk, rst, scl, sda, m_pull, sda_out, sda_oe, wp, write_busy;
    logic avs_read, avs_write, avs_waitrequest;
    logic [2:0] sel;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] a;
    logic [15:0] cor [4] = '{16'h17FF, 16'h1800, 16'h1800, 16'h17FF};
    logic [7:0] exp_mem [logic [12:0]];
    int n_errors = 0;
    int total_checks = 0;
    // Pull-up wins unless someone pulls low
    assign sda = ~(sda_oe | m_pull);
    always #2 mclk = ~mclk;
    twes_i2c_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(m_pull));
    twes_eeprom_slave #(.WC_CYCLES(WC), .DEV_TYPE(TYPE_CODE)) uut (.mclk(mclk), .rst(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_bit0(sel[0]), .select_pin_bit1(sel[1]),
        .select_pin_bit2(sel[2]), .write_protect(wp), .write_busy(write_busy), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic av(input logic wr, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] r);
        int k;
        avs_address <= ad;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        for (k = 0; k < 50; k++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k == 50) begin
            n_errors++;
            print_verdict();
        end
        @(posedge mclk);
    endtask
    function automatic logic [7:0] aw(input logic rw);
        return {TYPE_CODE, sel, rw};
    endfunction
    task automatic send(input logic [7:0] d, input logic e);
        logic ack;
        m.wr_byte(d, ack);
        chk({31'h0, ack}, {31'h0, e});
    endtask
    task automatic bwrite(input logic [15:0] ad, input logic [7:0] d);
        int k;
        m.start_c();
        send(aw(1'b0), 1'b1);
        send(ad[15:8], 1'b1);
        send(ad[7:0], 1'b1);
        send(d, 1'b1);
        m.stop_c();
        if (!(wp && ad[12:11] == 2'b11)) exp_mem[ad[12:0]] = d;
        av(1'b0, 4'h4, 32'h0, q);
        chk(q, 32'h1);
        m.start_c();
        send(aw(1'b0), 1'b0);
        m.stop_c();
        for (k = 0; k < 200 && q[0] !== 1'b0; k++) av(1'b0, 4'h4, 32'h0, q);
        if (k == 200) begin
            n_errors++;
            print_verdict();
        end
        m.start_c();
        send(aw(1'b0), 1'b1);
        m.stop_c();
    endtask
    task automatic rread(input logic [12:0] ad);
        logic [7:0] d;
        logic [12:0] nx;
        nx = ad + 13'h1;
        m.start_c();
        send(aw(1'b0), 1'b1);
        send({3'h0, ad[12:8]}, 1'b1);
        send(ad[7:0], 1'b1);
        m.start_c();
        send(aw(1'b1), 1'b1);
        m.rd_byte(1'b1, d);
        if (exp_mem.exists(ad)) chk({24'h0, d}, {24'h0, exp_mem[ad]});
        m.rd_byte(1'b0, d);
        if (exp_mem.exists(nx)) chk({24'h0, d}, {24'h0, exp_mem[nx]});
        m.rd_byte(1'b0, d);
        chk({24'h0, d}, 32'hFF);
        m.stop_c();
        av(1'b0, 4'h8, 32'h0, q);
        chk(q, {19'h0, nx});
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        wp = 1'b0;
        void'($urandom(67421));
        sel = 3'($urandom);
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        av(1'b0, 4'h0, 32'h0, q);
        chk(q, 32'h1);
        av(1'b0, 4'hC, 32'h0, q);
        chk(q, 32'h0);
        // Disabled device must stay silent
        av(1'b1, 4'h0, 32'h0, q);
        m.start_c();
        send(aw(1'b0), 1'b0);
        m.stop_c();
        av(1'b1, 4'h0, 32'h1, q);
        m.start_c();
        send({~TYPE_CODE, sel, 1'b0}, 1'b0);
        m.stop_c();
        m.start_c();
        send({TYPE_CODE, ~sel, 1'b1}, 1'b0);
        m.stop_c();
        for (int i = 0; i < 8; i++) begin
            a = (i < 4) ? cor[i] : 16'($urandom);
            wp <= (i < 4) ? 1'(i > 1) : 1'($urandom);
            @(posedge mclk);
            bwrite(a, 8'($urandom));
            rread(a[12:0]);
        end
        print_verdict();
    end
endmodule
